// [tdm_defines.svh]
`ifndef TDM_DEFINES_SVH
`define TDM_DEFINES_SVH
// ----------------------------------------
// register offsets (8-bit pointer space)
// ----------------------------------------
`define TDM_OFS_LOCAL 8'h00
`define TDM_OFS_REM_HI 8'h01
`define TDM_OFS_STATUS 8'h02
`define TDM_OFS_CONFIG 8'h03
`define TDM_OFS_RATE 8'h04
`define TDM_OFS_LIM_LH 8'h05
`define TDM_OFS_LIM_LL 8'h06
`define TDM_OFS_LIM_RH 8'h07
`define TDM_OFS_LIM_RL 8'h08
`define TDM_OFS_LIM_RHL 8'h09
`define TDM_OFS_LIM_RLL 8'h0a
`define TDM_OFS_LIM_LT 8'h0b
`define TDM_OFS_LIM_RT 8'h0c
`define TDM_OFS_TMO 8'h0d
`define TDM_OFS_REM_LO 8'h10
// ----------------------------------------
// limit array indices and reset values
// ----------------------------------------
`define TDM_LI_LH 3'h0
`define TDM_LI_LL 3'h1
`define TDM_LI_RH 3'h2
`define TDM_LI_RL 3'h3
`define TDM_LI_RHL 3'h4
`define TDM_LI_RLL 3'h5
`define TDM_LI_LT 3'h6
`define TDM_LI_RT 3'h7
`define TDM_LIM_HIGH_RST 8'h55
`define TDM_LIM_LOW_RST 8'h00
`define TDM_CFG_RST 8'h00
`define TDM_RATE_RST 4'h8
`define TDM_RATE_MAX 4'ha
// ----------------------------------------
// data format, quarter degrees
// ----------------------------------------
`define TDM_EXT_OFFSET 12'sh100
`define TDM_DEF_MAX 12'sh1f4
`define TDM_EXT_MIN 12'shf00
`define TDM_EXT_MAX 12'sh2ff
// ----------------------------------------
// timing
// ----------------------------------------
`define TDM_CLK_MHZ 200
`define TDM_TMO_MS 25
`define TDM_TMO_CYC (`TDM_TMO_MS * `TDM_CLK_MHZ * 1000)
`define TDM_CONV_BASE_MS 16000
`define TDM_CONV_BASE_CYC (64'(`TDM_CONV_BASE_MS) * `TDM_CLK_MHZ * 1000)
`endif

// [tdm_pkg.sv]
package tdm_pkg;
  typedef struct packed {
    logic alarm_mask;
    logic standby;
    logic alarm_as_shutdown;
    logic [1:0] spare_hi;
    logic ext_range;
    logic [1:0] spare_lo;
  } tdm_cfg_t;
  typedef struct packed {
    logic busy;
    logic local_high;
    logic local_low;
    logic remote_high;
    logic remote_low;
    logic sensor_fault;
    logic remote_shdn;
    logic local_shdn;
  } tdm_status_t;
  typedef struct packed {
    logic done;
    logic fault;
    logic signed [11:0] temp;
  } tdm_conv_t;
  typedef enum logic [2:0] {CV_WAIT = 3'b001, CV_LOCAL = 3'b010, CV_REMOTE = 3'b100} tdm_cv_state_t;
  typedef enum logic [4:0] {
    SB_IDLE = 5'b00001, SB_ADDR = 5'b00010, SB_PTR = 5'b00100, SB_WDATA = 5'b01000, SB_RDATA = 5'b10000
  } tdm_sb_state_t;
endpackage : tdm_pkg

// [tdm_monitor.sv]
// Functional notes
// - converter runs continuously, starting each conversion without host trigger
// - conversions alternate between local and remote channel
// - each result is written to its own channel's value register
// - results compared against high, low, shutdown limits in eight limit registers
// - out-of-limit outcomes set flag bits in the readable status register
// - alarm output asserts when a result is above high or below low
// - alarm output also asserts on an external sensor fault
// - shutdown output goes low while a temperature exceeds its shutdown limit
// - configuration can turn the alarm pin into a second shutdown output
// - limits and configuration written over SMBus; every register reads back
// - standby control stops the free-running conversions
// - controls for range, alarm mask and alarm pin function
// - host-selected rate sets how often the measurement sequence repeats
// - user-enabled SMBus timeout of 25 ms, off after reset
// - configuration bit 2 selects extended range, else default range
// - extended range reports offset binary with 64 degree offset, default plain binary
// - reading remote low byte freezes remote high byte until it is read
// - local result at 0x00, remote high at 0x01, remote low at 0x10
`include "tdm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tdm_monitor #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a, // arbitrary value
  parameter int unsigned TMO_CYC = `TDM_TMO_CYC,
  parameter logic [31:0] CONV_BASE_CYC = 32'(`TDM_CONV_BASE_CYC)
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic serial_clk_pin,
  input wire logic serial_data_pin,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire tdm_pkg::tdm_conv_t conv,
  output logic conv_start,
  output logic conv_remote,
  output logic alarm_out_n,
  output logic overtemp_shutdown_out_n
);
  import tdm_pkg::*;
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] scl_s, sda_s;
  logic scl_f, sda_f, scl_d, sda_d;
  always_ff @(posedge mclk) begin
    scl_s <= {scl_s[1:0], serial_clk_pin};
    sda_s <= {sda_s[1:0], serial_data_pin};
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
      if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end
  wire logic scl_rise = scl_f & ~scl_d;
  wire logic scl_fall = ~scl_f & scl_d;
  wire logic bus_start = scl_f & scl_d & sda_d & ~sda_f;
  wire logic bus_stop = scl_f & scl_d & ~sda_d & sda_f;
  // ----------------------------------------
  // register state
  // ----------------------------------------
  tdm_cfg_t cfg;
  tdm_status_t status;
  logic [3:0] rate;
  logic tmo_en;
  logic [7:0] lim [8];
  logic [7:0] local_val, rem_hi, rem_lo;
  logic [9:0] rem_cur;
  logic lock;
  logic wr_en, rd_en;
  logic [7:0] ptr, wr_data;
  logic [2:0] wr_idx;
  logic wr_lim;
  always_comb begin
    wr_lim = 1'b1;
    unique case (ptr)
      `TDM_OFS_LIM_LH: wr_idx = `TDM_LI_LH;
      `TDM_OFS_LIM_LL: wr_idx = `TDM_LI_LL;
      `TDM_OFS_LIM_RH: wr_idx = `TDM_LI_RH;
      `TDM_OFS_LIM_RL: wr_idx = `TDM_LI_RL;
      `TDM_OFS_LIM_RHL: wr_idx = `TDM_LI_RHL;
      `TDM_OFS_LIM_RLL: wr_idx = `TDM_LI_RLL;
      `TDM_OFS_LIM_LT: wr_idx = `TDM_LI_LT;
      `TDM_OFS_LIM_RT: wr_idx = `TDM_LI_RT;
      default: begin
        wr_idx = `TDM_LI_LH;
        wr_lim = 1'b0;
      end
    endcase
  end
  for (genvar i = 0; i < 8; i++) begin : g_lim
    localparam logic [7:0] RST_V = (i == 1 || i == 3 || i == 5) ? `TDM_LIM_LOW_RST : `TDM_LIM_HIGH_RST;
    always_ff @(posedge mclk) begin
      if (rst) lim[i] <= RST_V;
      else if (wr_en && wr_lim && wr_idx == 3'(i)) lim[i] <= wr_data;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg <= `TDM_CFG_RST;
      rate <= `TDM_RATE_RST;
      tmo_en <= 1'b0;
    end else if (wr_en) begin
      if (ptr == `TDM_OFS_CONFIG) cfg <= wr_data;
      if (ptr == `TDM_OFS_RATE) rate <= (wr_data[3:0] > `TDM_RATE_MAX) ? `TDM_RATE_MAX : wr_data[3:0];
      if (ptr == `TDM_OFS_TMO) tmo_en <= wr_data[0];
    end
  end
  function automatic logic [7:0] rd_mux(input logic [7:0] p);
    unique case (p)
      `TDM_OFS_LOCAL: return local_val;
      `TDM_OFS_REM_HI: return rem_hi;
      `TDM_OFS_REM_LO: return rem_lo;
      `TDM_OFS_STATUS: return status;
      `TDM_OFS_CONFIG: return cfg;
      `TDM_OFS_RATE: return {4'h0, rate};
      `TDM_OFS_TMO: return {7'h00, tmo_en};
      `TDM_OFS_LIM_LH: return lim[`TDM_LI_LH];
      `TDM_OFS_LIM_LL: return lim[`TDM_LI_LL];
      `TDM_OFS_LIM_RH: return lim[`TDM_LI_RH];
      `TDM_OFS_LIM_RL: return lim[`TDM_LI_RL];
      `TDM_OFS_LIM_RHL: return lim[`TDM_LI_RHL];
      `TDM_OFS_LIM_RLL: return lim[`TDM_LI_RLL];
      `TDM_OFS_LIM_LT: return lim[`TDM_LI_LT];
      `TDM_OFS_LIM_RT: return lim[`TDM_LI_RT];
      default: return 8'h00;
    endcase
  endfunction
  // read byte for the current pointer; a bit-select of a call result is not legal
  logic [7:0] rd_byte;
  always_comb rd_byte = rd_mux(ptr);
  // ----------------------------------------
  // smbus slave
  // ----------------------------------------
  tdm_sb_state_t sb;
  logic [3:0] bit_cnt;
  logic [7:0] shift, tx;
  logic rw, mack;
  logic [31:0] tmo_cnt;
  wire logic tmo_hit = tmo_en && sb != SB_IDLE && !scl_f && tmo_cnt == 32'(TMO_CYC - 1);
  always_ff @(posedge mclk) begin
    if (rst || !tmo_en || scl_f || sb == SB_IDLE) tmo_cnt <= 32'h0;
    else tmo_cnt <= tmo_cnt + 32'h1;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      sb <= SB_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      mack <= 1'b0;
      ptr <= 8'h00;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      wr_data <= 8'h00;
      serial_data_oe <= 1'b0;
      serial_data_out <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      if (bus_stop || tmo_hit) begin
        sb <= SB_IDLE;
        serial_data_oe <= 1'b0;
      end else if (bus_start) begin
        sb <= SB_ADDR;
        bit_cnt <= 4'h0;
        serial_data_oe <= 1'b0;
      end else if (scl_rise && sb != SB_IDLE) begin
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt < 4'h8) shift <= {shift[6:0], sda_f};
        else mack <= ~sda_f;
      end else if (scl_fall && sb != SB_IDLE) begin
        if (bit_cnt == 4'h8) begin
          serial_data_oe <= sb != SB_RDATA;
          unique case (sb)
            SB_ADDR: begin
              rw <= shift[0];
              if (shift[7:1] != SLAVE_ADDR) begin
                sb <= SB_IDLE;
                serial_data_oe <= 1'b0;
              end
            end
            SB_PTR: ptr <= shift;
            SB_WDATA: begin
              wr_data <= shift;
              wr_en <= 1'b1;
            end
            default: ;
          endcase
        end else if (bit_cnt == 4'h9) begin
          bit_cnt <= 4'h0;
          serial_data_oe <= 1'b0;
          if ((sb == SB_ADDR && rw) || (sb == SB_RDATA && mack)) begin
            sb <= SB_RDATA;
            tx <= {rd_byte[6:0], 1'b0};
            serial_data_oe <= ~rd_byte[7];
            rd_en <= 1'b1;
          end else if (sb == SB_RDATA) sb <= SB_IDLE;
          else if (sb == SB_ADDR) sb <= SB_PTR;
          else sb <= SB_WDATA;
        end else if (sb == SB_RDATA) begin
          serial_data_oe <= ~tx[7];
          tx <= {tx[6:0], 1'b0};
        end
      end
    end
  end
  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  tdm_cv_state_t cv;
  logic [31:0] wait_cnt;
  logic cmp_l, cmp_r, fault_now;
  function automatic logic [9:0] fmt(input logic signed [11:0] t, input logic ext);
    logic signed [11:0] c;
    c = t;
    if (ext) begin
      if (c < `TDM_EXT_MIN) c = `TDM_EXT_MIN;
      else if (c > `TDM_EXT_MAX) c = `TDM_EXT_MAX;
      c = c + `TDM_EXT_OFFSET;
    end else begin
      if (c < 12'sh000) c = 12'sh000;
      else if (c > `TDM_DEF_MAX) c = `TDM_DEF_MAX;
    end
    return c[9:0];
  endfunction
  wire logic [9:0] fmt_now = fmt(conv.temp, cfg.ext_range);
  always_ff @(posedge mclk) begin
    if (rst) begin
      cv <= CV_WAIT;
      wait_cnt <= 32'h0;
      conv_start <= 1'b0;
      conv_remote <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      unique case (cv)
        CV_WAIT: begin
          if (!cfg.standby && wait_cnt == 32'h0) begin
            cv <= CV_LOCAL;
            conv_start <= 1'b1;
            conv_remote <= 1'b0;
          end else if (wait_cnt != 32'h0) wait_cnt <= wait_cnt - 32'h1;
        end
        CV_LOCAL: if (conv.done) begin
          cv <= CV_REMOTE;
          conv_start <= 1'b1;
          conv_remote <= 1'b1;
        end
        CV_REMOTE: if (conv.done) begin
          cv <= CV_WAIT;
          wait_cnt <= CONV_BASE_CYC >> rate;
        end
        default: cv <= CV_WAIT;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      local_val <= 8'h00;
      rem_hi <= 8'h00;
      rem_lo <= 8'h00;
      rem_cur <= 10'h000;
      lock <= 1'b0;
      cmp_l <= 1'b0;
      cmp_r <= 1'b0;
      fault_now <= 1'b0;
    end else begin
      cmp_l <= conv.done && cv == CV_LOCAL;
      cmp_r <= conv.done && cv == CV_REMOTE;
      if (conv.done && cv == CV_LOCAL) local_val <= fmt_now[9:2];
      if (conv.done && cv == CV_REMOTE) begin
        rem_lo <= {fmt_now[1:0], 6'h00};
        rem_cur <= fmt_now;
        fault_now <= conv.fault;
        if (!lock) rem_hi <= fmt_now[9:2];
      end
      if (rd_en && ptr == `TDM_OFS_REM_LO) lock <= 1'b1;
      else if (rd_en && ptr == `TDM_OFS_REM_HI) lock <= 1'b0;
    end
  end
  // ----------------------------------------
  // limit compare, status, pins
  // ----------------------------------------
  tdm_status_t st_set;
  logic shdn_l, shdn_r;
  always_comb begin
    st_set = '0;
    st_set.local_high = cmp_l && local_val > lim[`TDM_LI_LH];
    st_set.local_low = cmp_l && local_val < lim[`TDM_LI_LL];
    st_set.local_shdn = cmp_l && local_val > lim[`TDM_LI_LT];
    st_set.remote_high = cmp_r && rem_cur > {lim[`TDM_LI_RH], lim[`TDM_LI_RHL][7:6]};
    st_set.remote_low = cmp_r && rem_cur < {lim[`TDM_LI_RL], lim[`TDM_LI_RLL][7:6]};
    st_set.remote_shdn = cmp_r && rem_cur[9:2] > lim[`TDM_LI_RT];
    st_set.sensor_fault = cmp_r && fault_now;
  end
  wire logic st_clr = rd_en && ptr == `TDM_OFS_STATUS;
  always_ff @(posedge mclk) begin
    if (rst) begin
      status <= '0;
      shdn_l <= 1'b0;
      shdn_r <= 1'b0;
    end else begin
      status <= (st_clr ? tdm_status_t'(8'h00) : status) | st_set;
      status.busy <= cv != CV_WAIT;
      if (cmp_l) shdn_l <= st_set.local_shdn;
      if (cmp_r) shdn_r <= st_set.remote_shdn;
    end
  end
  wire logic alarm_cond = status.local_high | status.local_low | status.remote_high | status.remote_low;
  always_ff @(posedge mclk) begin
    if (rst) begin
      alarm_out_n <= 1'b1;
      overtemp_shutdown_out_n <= 1'b1;
    end else begin
      overtemp_shutdown_out_n <= ~(shdn_l | shdn_r);
      if (cfg.alarm_as_shutdown) alarm_out_n <= ~(shdn_l | shdn_r);
      else alarm_out_n <= ~(~cfg.alarm_mask & (alarm_cond | status.sensor_fault));
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_local_done;
    cv == CV_LOCAL && conv.done;
  endsequence
  sequence s_remote_start;
    conv_start && conv_remote;
  endsequence
  a_conv_free_run: assert property (@(posedge mclk) disable iff (rst)
    cv == CV_WAIT && wait_cnt == 32'h0 && !cfg.standby |=> conv_start && !conv_remote)
    else $error("conversion did not start on its own");
  a_chan_alternate: assert property (@(posedge mclk) disable iff (rst)
    s_local_done |=> s_remote_start)
    else $error("remote conversion did not follow local");
  a_local_store: assert property (@(posedge mclk) disable iff (rst)
    s_local_done |=> local_val == $past(fmt_now[9:2]) && cmp_l)
    else $error("local result not stored before compare");
  a_flag_high: assert property (@(posedge mclk) disable iff (rst)
    cmp_l && local_val > lim[`TDM_LI_LH] |=> status.local_high)
    else $error("local high flag not set");
  a_alarm_assert: assert property (@(posedge mclk) disable iff (rst)
    (status.remote_high || status.local_low) && !cfg.alarm_mask && !cfg.alarm_as_shutdown |=> !alarm_out_n)
    else $error("alarm not asserted on limit flag");
  a_fault_alarm: assert property (@(posedge mclk) disable iff (rst)
    status.sensor_fault && !cfg.alarm_mask && !cfg.alarm_as_shutdown |=> !alarm_out_n)
    else $error("alarm not asserted on sensor fault");
  a_shutdown_low: assert property (@(posedge mclk) disable iff (rst)
    cmp_r && st_set.remote_shdn |=> ##1 !overtemp_shutdown_out_n)
    else $error("shutdown output not driven low");
  a_alt_shutdown: assert property (@(posedge mclk) disable iff (rst)
    cfg.alarm_as_shutdown |=> alarm_out_n == $past(~(shdn_l | shdn_r)))
    else $error("second shutdown output mismatch");
  a_standby_stop: assert property (@(posedge mclk) disable iff (rst)
    cfg.standby && cv == CV_WAIT |=> !conv_start)
    else $error("conversion started in standby");
  a_timeout_off: assert property (@(posedge mclk) disable iff (rst)
    !tmo_en |=> tmo_cnt == 32'h0 && !tmo_hit)
    else $error("timeout runs while disabled");
  a_high_lock: assert property (@(posedge mclk) disable iff (rst)
    lock |=> $stable(rem_hi))
    else $error("remote high byte changed while locked");
endmodule : tdm_monitor
`default_nettype wire

// [tdm_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tdm_host_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam int Q = 16;
  localparam logic [7:0] AW = {ADDR, 1'b0};
  int nak_cnt;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    nak_cnt = 0;
  end
  // ----------------------------------------
  // bit level, 64 ns link clock, idles high between frames
  // ----------------------------------------
  task automatic sta();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : sta
  task automatic sto();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #(4 * Q);
  endtask : sto
  task automatic put_bit(input logic b);
    sda_low = ~b;
    #Q scl = 1'b1;
    #(2 * Q) scl = 1'b0;
    #Q;
  endtask : put_bit
  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q b = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : get_bit
  task automatic put_byte(input logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    if (b !== 1'b0) begin
      nak_cnt++;
    end
  endtask : put_byte
  // ----------------------------------------
  // register transactions
  // ----------------------------------------
  task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
    sta();
    put_byte(AW);
    put_byte(p);
    put_byte(d);
    sto();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
    sta();
    put_byte(AW);
    put_byte(p);
    sta();
    put_byte({ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'b1);
    sto();
  endtask : read_reg
  // clock held low inside the ack slot; held reports whether data is still pulled
  task automatic stall(input int hold, output logic held);
    sta();
    for (int i = 7; i >= 0; i--) begin
      put_bit(AW[i]);
    end
    sda_low = 1'b0;
    #hold held = ~sda;
    #Q scl = 1'b1;
    #(2 * Q) scl = 1'b0;
    #Q;
    sto();
  endtask : stall
endmodule : tdm_host_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tdm_pkg::*;
  localparam logic [6:0] ADDR = 7'h2a; // arbitrary value
  logic mclk = 1'b0;
  logic rst = 1'b1;
  tdm_conv_t conv = '0;
  logic conv_start, conv_remote, alarm_out_n, overtemp_shutdown_out_n;
  logic serial_data_out, serial_data_oe, scl, host_low, held, ch;
  logic rem_fault = 1'b0;
  logic exp_ch = 1'b0;
  logic [7:0] rd_d;
  wire logic sda_w;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_pair = 0;
  int n_start = 0;
  int t_done = 0;
  int gap = 0;
  int loc_t = 100;
  int rem_t = 201;
  int k;
  assign sda_w = ~(host_low | serial_data_oe);
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  tdm_monitor #(.SLAVE_ADDR(ADDR), .TMO_CYC(50), .CONV_BASE_CYC(32'd2048)) tdm_monitor_inst (
    .mclk(mclk), .rst(rst), .serial_clk_pin(scl), .serial_data_pin(sda_w),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe), .conv(conv),
    .conv_start(conv_start), .conv_remote(conv_remote), .alarm_out_n(alarm_out_n),
    .overtemp_shutdown_out_n(overtemp_shutdown_out_n));
  tdm_host_model #(.ADDR(ADDR)) tdm_host_model_inst (.scl(scl), .sda_low(host_low), .sda(sda_w));
  // ----------------------------------------
  // converter model and reference helpers
  // ----------------------------------------
  always begin
    // the remote start is already showing when a local conversion ends
    if (conv_start !== 1'b1 || rst !== 1'b0) begin
      @(posedge mclk);
      #1;
    end
    if (conv_start === 1'b1 && rst === 1'b0) begin
      ch = conv_remote;
      n_start++;
      if (ch !== exp_ch) begin
        chk("channel", 8'(exp_ch), 8'(ch));
      end
      exp_ch = ~exp_ch;
      if (ch === 1'b0) begin
        gap = cyc - t_done;
      end
      repeat ($urandom_range(3, 10)) @(posedge mclk);
      #1 conv.done = 1'b1;
      conv.temp = 12'(ch ? rem_t : loc_t);
      conv.fault = ch & rem_fault;
      @(posedge mclk);
      #1 conv.done = 1'b0;
      if (ch === 1'b1) begin
        t_done = cyc;
        n_pair++;
      end
    end
  end
  function automatic logic [7:0] hb(input int q, input bit x);
    int v;
    v = x ? q + 256 : q;
    v = v < 0 ? 0 : v;
    v = x ? (v > 1023 ? 1023 : v) : (v > 500 ? 500 : v);
    return 8'(v >>> 2);
  endfunction : hb
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk
  task automatic rd(input logic [7:0] p, input logic [7:0] m, input logic [7:0] e);
    tdm_host_model_inst.read_reg(p, rd_d);
    chk($sformatf("reg %h", p), e, rd_d & m);
  endtask : rd
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    tdm_host_model_inst.write_reg(p, d);
  endtask : wr
  task automatic wpair();
    int t;
    t = n_pair + 2;
    for (int i = 0; i < 20000 && n_pair < t; i++) begin
      @(posedge mclk);
    end
    chk("pairs", 8'h1, 8'(n_pair >= t));
    repeat (8) @(posedge mclk);
    #1;
  endtask : wpair
  task automatic report_and_stop();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(6));
    repeat (4) @(posedge mclk);
    #1 rst = 1'b0;
    chk("alarm_n", 8'h1, 8'(alarm_out_n));
    chk("shdn_n", 8'h1, 8'(overtemp_shutdown_out_n));
    loc_t = 4 * int'($urandom_range(1, 80));
    wpair();
    rd(8'h00, 8'hff, hb(loc_t, 0));
    rd(8'h10, 8'hff, 8'h40);
    rd(8'h01, 8'hff, hb(rem_t, 0));
    rd(8'h10, 8'hff, 8'h40);
    rem_t = 240;
    wpair();
    rd(8'h01, 8'hff, hb(201, 0));
    wpair();
    rd(8'h01, 8'hff, hb(rem_t, 0));
    wr(8'h03, 8'h04);
    wpair();
    rd(8'h00, 8'hff, hb(loc_t, 1));
    chk("shdn_n", 8'h0, 8'(overtemp_shutdown_out_n));
    rd(8'h02, 8'h12, 8'h12);
    wr(8'h03, 8'h00);
    loc_t = 100;
    wpair();
    tdm_host_model_inst.read_reg(8'h02, rd_d);
    wr(8'h05, 8'd20);
    wpair();
    chk("alarm_n", 8'h0, 8'(alarm_out_n));
    rd(8'h02, 8'h7f, 8'h40);
    rd(8'h05, 8'hff, 8'd20);
    wr(8'h05, 8'h55);
    wpair();
    tdm_host_model_inst.read_reg(8'h02, rd_d);
    wpair();
    chk("alarm_n", 8'h1, 8'(alarm_out_n));
    rd(8'h02, 8'h7f, 8'h00);
    loc_t = 360;
    wpair();
    chk("shdn_n", 8'h0, 8'(overtemp_shutdown_out_n));
    rd(8'h02, 8'h7f, 8'h41);
    wr(8'h03, 8'h20);
    loc_t = 100;
    wpair();
    chk("shdn_n", 8'h1, 8'(overtemp_shutdown_out_n));
    chk("alarm_n", 8'h1, 8'(alarm_out_n));
    loc_t = 360;
    wpair();
    chk("alarm_n", 8'h0, 8'(alarm_out_n));
    loc_t = 100;
    wr(8'h03, 8'h00);
    wpair();
    tdm_host_model_inst.read_reg(8'h02, rd_d);
    rem_fault = 1'b1;
    wpair();
    chk("alarm_n", 8'h0, 8'(alarm_out_n));
    wr(8'h03, 8'h80);
    chk("alarm_n", 8'h1, 8'(alarm_out_n));
    wr(8'h03, 8'h00);
    rd(8'h02, 8'h04, 8'h04);
    rem_fault = 1'b0;
    wpair();
    tdm_host_model_inst.read_reg(8'h02, rd_d);
    wpair();
    chk("alarm_n", 8'h1, 8'(alarm_out_n));
    wr(8'h03, 8'h40);
    repeat (100) @(posedge mclk);
    k = n_start;
    repeat (600) @(posedge mclk);
    chk("starts", 8'(k), 8'(n_start));
    wr(8'h03, 8'h00);
    repeat (100) @(posedge mclk);
    chk("resume", 8'h1, 8'(n_start > k));
    wr(8'h04, 8'h02);
    wpair();
    wpair();
    chk("gap", 8'h1, 8'(gap >= 510 && gap <= 518));
    tdm_host_model_inst.stall(1000, held);
    chk("held", 8'h1, 8'(held));
    wr(8'h0d, 8'h01);
    tdm_host_model_inst.stall(1000, held);
    chk("held", 8'h0, 8'(held));
    rd(8'h0d, 8'h01, 8'h01);
    chk("nak", 8'h0, 8'(tdm_host_model_inst.nak_cnt));
    rd(8'h20, 8'hff, 8'h00);
    chk("sda_out", 8'h0, 8'(serial_data_out));
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
